/* rtl/wpc_pkg.sv */
// Constants, state encodings and field positions shared by the
// write-protect controller ends.
// Assumes a single 50 MHz core clock on both ends.
package wpc_pkg;
   localparam logic [15:0] WPC_REG_ADDR = 16'hFFFF;
   localparam int WPC_ARM_BIT = 7;
   localparam int WPC_HI_BIT = 4;
   localparam int WPC_LO_BIT = 3;
   localparam int WPC_CWU_BIT = 2;
   localparam int WPC_AWU_BIT = 1;
   localparam logic [7:0] WPC_RSV_MASK = 8'h61;
   localparam logic [7:0] WPC_SET_AWU = 8'h02;
   localparam logic [7:0] WPC_CLR_AWU = 8'h00;
   localparam logic [7:0] WPC_SET_CWU = 8'h06;
   localparam logic [7:0] WPC_STEP3_MASK = 8'h67;
   localparam logic [7:0] WPC_STEP3_VAL = 8'h02;
   localparam logic [11:0] WPC_QTR_BASE = 12'hC00;
   localparam logic [11:0] WPC_HALF_BASE = 12'h800;
   // Nonvolatile bits start blank after reset.
   localparam logic WPC_ARM_RST = 1'b0;
   localparam logic WPC_HI_RST = 1'b0;
   localparam logic WPC_LO_RST = 1'b0;
   localparam int WPC_CLK_HZ = 50_000_000;
   localparam int WPC_NV_PROGRAM_TIME_MS = 10;
   localparam int WPC_NV_PROGRAM_CYC =
      (WPC_CLK_HZ / 1000) * WPC_NV_PROGRAM_TIME_MS;
   localparam logic [7:0] WPC_HOFS_ADDR = 8'h00;
   localparam logic [7:0] WPC_HOFS_DATA = 8'h04;
   localparam logic [7:0] WPC_HOFS_CTRL = 8'h08;
   localparam logic [7:0] WPC_HOFS_STAT = 8'h0C;
   localparam int WPC_CTRL_GO = 0;
   localparam int WPC_CTRL_WE = 1;
   localparam int WPC_CTRL_STOP = 2;

   typedef enum logic [2:0]
   {
      WPC_DS_IDLE = 3'b001,
      WPC_DS_RDWAIT = 3'b010,
      WPC_DS_PROG = 3'b100
   } wpc_dstate_t;

   typedef enum logic [1:0]
   {
      WPC_HS_IDLE = 2'b01,
      WPC_HS_WAIT = 2'b10
   } wpc_hstate_t;
endpackage

/* rtl/wpc_link_if.sv */
// Transaction-level carrier of the two-wire bus between master and device.
// Each request is one framed operation with a single data byte.
interface wpc_link_if;
   logic req;
   logic we;
   logic stop;
   logic [15:0] addr;
   logic [7:0] wdata;
   logic done;
   logic addr_ack;
   logic data_ack;
   logic [7:0] rdata;

   modport dev
   (
      input req, we, stop, addr, wdata,
      output done, addr_ack, data_ack, rdata
   );

   modport host
   (
      output req, we, stop, addr, wdata,
      input done, addr_ack, data_ack, rdata
   );
endinterface

/* rtl/wpc_prog_timer.sv */
// Self-timed nonvolatile program cycle counter.
// Assumes i_start only arrives while the timer is idle.
module wpc_prog_timer #(
   parameter int unsigned CYCLES = 16
)
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Control
   input wire logic i_start,
   output logic o_done
);
   import wpc_pkg::*;
   localparam int W = $clog2(CYCLES + 1);

   typedef struct packed
   {
      logic busy;
      logic done;
      logic [W-1:0] cnt;
   } wpc_tmr_t;

   wpc_tmr_t s;
   wpc_tmr_t next_s;

   always_comb
   begin
      next_s = s;
      next_s.done = 1'b0;
      if (i_start)
      begin
         next_s.busy = 1'b1;
         next_s.cnt = W'(CYCLES);
      end
      else if (s.busy)
      begin
         next_s.cnt = s.cnt - W'(1);
         if (s.cnt == W'(1))
         begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign o_done = s.done;
endmodule // wpc_prog_timer

/* rtl/wpc_dev.sv */
// Device end: protection register, volatile unlock latches and the
// write gating for a 4K x 8 serial memory array.
// Assumes the master frames one operation per request and keeps its
// own duties; the array storage itself lives outside this module.
// Behaviour
// - armed-and-pinned arm bit cannot be cleared
// - master writes zeros in bits 0,5,6
// - register read returns zero in 0,5,6
// - both unlock latches clear at power-up
// - array unlock clear: other writes nacked
// - 00000010 to top address sets array unlock
// - array unlock stays until 00000000 or reset
// - latch-only writes start no program cycle
// - config unlock clear blocks lock/arm changes
// - config unlock clears after any program
// - config unlock set forbids clearing array unlock
// - 00000010 with config unlock programs, clears
// - step two 00000110 sets config unlock
// - step three u00xy010 programs arm, locks
// - master may start at step two
// - step three with config bit stays step two
// - pin and arm high abort register program
// - master waits or polls after step three
// - step three ended by start aborts
// - lock bits choose none, quarter, half, all
// - only lock/arm bits need pin and arm
// - locked array write acked, discarded silently
// - bad reserved bits: register write not done
module wpc_dev #(
   parameter int unsigned NV_PROGRAM_CYC = wpc_pkg::WPC_NV_PROGRAM_CYC
)
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Bus side
   wpc_link_if.dev link,
   // Protect pin
   input wire logic i_protect_pin,
   // Array side
   input wire logic [7:0] i_arr_rdata,
   output logic o_arr_we,
   output logic [11:0] o_arr_addr,
   output logic [7:0] o_arr_wdata,
   // Status
   output logic o_busy,
   output logic o_hw_protected,
   output logic [7:0] o_write_protect_control
);
   import wpc_pkg::*;

   typedef struct packed
   {
      wpc_dstate_t st;
      logic awu;
      logic cwu;
      logic arm;
      logic hi;
      logic lo;
      logic pend_arm;
      logic pend_hi;
      logic pend_lo;
      logic prog_reg;
      logic tmr_start;
      logic done;
      logic addr_ack;
      logic data_ack;
      logic [7:0] rdata;
      logic arr_we;
      logic [11:0] arr_addr;
      logic [7:0] arr_wdata;
      logic hwp;
      logic [7:0] reg_view;
      logic busy;
   } wpc_dev_t;

   localparam wpc_dev_t DEV_RST = '{
      st: WPC_DS_IDLE,
      arm: WPC_ARM_RST,
      hi: WPC_HI_RST,
      lo: WPC_LO_RST,
      default: '0
   };

   wpc_dev_t s;
   wpc_dev_t next_s;
   logic tmr_done;
   logic is_reg;
   logic hwp;
   logic locked;
   logic [7:0] wd;
   logic [7:0] view;

   wpc_prog_timer #(
      .CYCLES(NV_PROGRAM_CYC)
   ) u_timer (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_start(s.tmr_start),
      .o_done(tmr_done)
   );

   always_comb
   begin
      unique case ({s.hi, s.lo})
         2'b00: locked = 1'b0;
         2'b01: locked = link.addr[11:0] >= WPC_QTR_BASE;
         2'b10: locked = link.addr[11:0] >= WPC_HALF_BASE;
         2'b11: locked = 1'b1;
      endcase
   end

   assign is_reg = link.addr == WPC_REG_ADDR;
   assign hwp = i_protect_pin & s.arm;
   assign wd = link.wdata;
   // Unused positions are wired to zero.
   assign view = {s.arm, 2'b00, s.hi, s.lo, s.cwu, s.awu, 1'b0};

   always_comb
   begin
      next_s = s;
      next_s.done = 1'b0;
      next_s.arr_we = 1'b0;
      next_s.tmr_start = 1'b0;
      next_s.hwp = hwp;
      next_s.reg_view = view;
      unique case (s.st)
         WPC_DS_IDLE:
         begin
            if (link.req && !link.we)
            begin
               next_s.addr_ack = 1'b1;
               next_s.data_ack = 1'b1;
               if (is_reg)
               begin
                  next_s.rdata = view;
                  next_s.done = 1'b1;
               end
               else
               begin
                  next_s.arr_addr = link.addr[11:0];
                  next_s.st = WPC_DS_RDWAIT;
               end
            end
            else if (link.req && is_reg)
            begin
               next_s.addr_ack = 1'b1;
               next_s.data_ack = 1'b1;
               next_s.done = 1'b1;
               // A frame closed by a start changes nothing.
               if ((wd & WPC_RSV_MASK) != 8'h00 || !link.stop)
               begin
                  next_s.done = 1'b1;
               end
               else if (s.cwu)
               begin
                  // Only this path may touch lock and arm.
                  if ((wd & WPC_STEP3_MASK) == WPC_STEP3_VAL)
                  begin
                     if (!hwp)
                     begin
                        next_s.pend_arm = wd[WPC_ARM_BIT];
                        next_s.pend_hi = wd[WPC_HI_BIT];
                        next_s.pend_lo = wd[WPC_LO_BIT];
                        next_s.prog_reg = 1'b1;
                        next_s.tmr_start = 1'b1;
                        next_s.st = WPC_DS_PROG;
                     end
                  end
                  // Config bit set or a plain clear: stay at step two.
               end
               else if (wd == WPC_SET_AWU)
                  next_s.awu = 1'b1;
               else if (wd == WPC_CLR_AWU)
                  next_s.awu = 1'b0;
               else if (wd == WPC_SET_CWU && s.awu)
                  next_s.cwu = 1'b1;
            end
            else if (link.req)
            begin
               next_s.addr_ack = 1'b1;
               next_s.data_ack = s.awu;
               next_s.done = 1'b1;
               // Locked bytes are acked and dropped.
               if (s.awu && !locked && link.stop)
               begin
                  next_s.arr_we = 1'b1;
                  next_s.arr_addr = link.addr[11:0];
                  next_s.arr_wdata = wd;
                  next_s.prog_reg = 1'b0;
                  next_s.tmr_start = 1'b1;
                  next_s.st = WPC_DS_PROG;
               end
            end
         end
         WPC_DS_RDWAIT:
         begin
            // One cycle lets the array answer the latched address.
            next_s.rdata = i_arr_rdata;
            next_s.done = 1'b1;
            next_s.st = WPC_DS_IDLE;
         end
         WPC_DS_PROG:
         begin
            // The device does not answer its address while programming.
            if (link.req)
            begin
               next_s.done = 1'b1;
               next_s.addr_ack = 1'b0;
               next_s.data_ack = 1'b0;
            end
            if (tmr_done)
            begin
               if (s.prog_reg)
               begin
                  next_s.arm = s.pend_arm;
                  next_s.hi = s.pend_hi;
                  next_s.lo = s.pend_lo;
               end
               next_s.cwu = 1'b0;
               next_s.st = WPC_DS_IDLE;
            end
         end
      endcase
      // Busy is registered so the status pin carries no decode glitches.
      next_s.busy = next_s.st == WPC_DS_PROG ? 1'b1 : 1'b0;
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
         s <= DEV_RST;
      else
         s <= next_s;
   end

   assign link.done = s.done;
   assign link.addr_ack = s.addr_ack;
   assign link.data_ack = s.data_ack;
   assign link.rdata = s.rdata;
   assign o_arr_we = s.arr_we;
   assign o_arr_addr = s.arr_addr;
   assign o_arr_wdata = s.arr_wdata;
   assign o_busy = s.busy;
   assign o_hw_protected = s.hwp;
   assign o_write_protect_control = s.reg_view;
endmodule // wpc_dev

/* rtl/wpc_host.sv */
// Bus master end: software sets up one framed operation through
// Wishbone classic registers and reads back the device's answer.
// Assumes software polls the status word; there is no interrupt.
module wpc_host
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Wishbone classic slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic o_wb_ack,
   output logic [31:0] o_wb_dat,
   // Bus side
   wpc_link_if.host link
);
   import wpc_pkg::*;

   typedef struct packed
   {
      wpc_hstate_t st;
      logic req;
      logic we;
      logic stop;
      logic [15:0] addr;
      logic [7:0] wdata;
      logic done;
      logic addr_ack;
      logic data_ack;
      logic [7:0] rdata;
      logic wb_ack;
      logic [31:0] wb_dat;
   } wpc_host_t;

   localparam wpc_host_t HOST_RST = '{st: WPC_HS_IDLE, default: '0};

   wpc_host_t s;
   wpc_host_t next_s;
   logic hit;
   logic wr;
   logic [31:0] stat;

   assign hit = i_wb_cyc & i_wb_stb & ~s.wb_ack;
   assign wr = hit & i_wb_we;
   assign stat = {16'h0000, s.rdata, 4'h0, s.data_ack, s.addr_ack,
                  s.done, s.st == WPC_HS_WAIT ? 1'b1 : 1'b0};

   always_comb
   begin
      next_s = s;
      next_s.req = 1'b0;
      next_s.wb_ack = hit;
      if (hit)
      begin
         unique case (i_wb_adr)
            WPC_HOFS_ADDR: next_s.wb_dat = {16'h0000, s.addr};
            WPC_HOFS_DATA: next_s.wb_dat = {24'h000000, s.wdata};
            WPC_HOFS_STAT: next_s.wb_dat = stat;
            default: next_s.wb_dat = 32'h00000000;
         endcase
      end
      if (wr && i_wb_adr == WPC_HOFS_ADDR)
      begin
         if (i_wb_sel[0])
            next_s.addr[7:0] = i_wb_dat[7:0];
         if (i_wb_sel[1])
            next_s.addr[15:8] = i_wb_dat[15:8];
      end
      if (wr && i_wb_adr == WPC_HOFS_DATA && i_wb_sel[0])
         next_s.wdata = i_wb_dat[7:0];
      unique case (s.st)
         WPC_HS_IDLE:
         begin
            // A go while an operation runs is ignored.
            if (wr && i_wb_adr == WPC_HOFS_CTRL && i_wb_sel[0] &&
                i_wb_dat[WPC_CTRL_GO])
            begin
               next_s.we = i_wb_dat[WPC_CTRL_WE];
               next_s.stop = i_wb_dat[WPC_CTRL_STOP];
               next_s.req = 1'b1;
               next_s.done = 1'b0;
               next_s.st = WPC_HS_WAIT;
            end
         end
         WPC_HS_WAIT:
         begin
            // A nacked address is reported; software retries to poll.
            if (link.done)
            begin
               next_s.addr_ack = link.addr_ack;
               next_s.data_ack = link.data_ack;
               next_s.rdata = link.rdata;
               next_s.done = 1'b1;
               next_s.st = WPC_HS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_core_clk)
   begin
      if (i_rst)
         s <= HOST_RST;
      else
         s <= next_s;
   end

   assign o_wb_ack = s.wb_ack;
   assign o_wb_dat = s.wb_dat;
   assign link.req = s.req;
   assign link.we = s.we;
   assign link.stop = s.stop;
   assign link.addr = s.addr;
   assign link.wdata = s.wdata;
endmodule // wpc_host

/* test/wpc_link_sva.sv */
// Checker for the link between the host and device ends.
// Assumes it sits beside the link instance that joins both ends.
module wpc_link_sva
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Link
   input wire logic req,
   input wire logic we,
   input wire logic stop,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic done,
   input wire logic addr_ack,
   input wire logic data_ack,
   input wire logic [7:0] rdata
);
   import wpc_pkg::*;
   logic pend;
   logic quiet;
   logic awu_clr;
   logic reg_op;
   assign reg_op = addr == WPC_REG_ADDR;
   // Remembers latch-only writes, and a read that showed the array lock shut.
   always_ff @(posedge i_core_clk)
   begin
      pend <= !i_rst && (req || (pend && !done));
      if (i_rst || done)
         quiet <= !i_rst && we && reg_op && addr_ack && (!stop
            || wdata == 8'h00 || wdata == 8'h06
            || (wdata & WPC_RSV_MASK) != 8'h00);
      if (i_rst)
         awu_clr <= 1'b0;
      else if (done && reg_op)
         awu_clr <= !we && addr_ack && !rdata[WPC_AWU_BIT];
   end
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   answer_bound_a:
      assert property (req |-> ##[1:2] done)
      else $error("request not answered in time");
   done_pulse_a:
      assert property (done |=> !done)
      else $error("done held too long");
   req_order_a:
      assert property (req |-> !pend && !done)
      else $error("request before answer");
   cmd_hold_a:
      assert property (done |-> $stable({we, stop, addr, wdata}))
      else $error("command moved before answer");
   reset_idle_a:
      assert property ($fell(i_rst) |-> !req && !done && rdata == 8'h00)
      else $error("link busy out of reset");
   rsv_zero_a:
      assert property (done && !we && reg_op && addr_ack
         |-> (rdata & WPC_RSV_MASK) == 8'h00)
      else $error("unused bits read nonzero");
   locked_nack_a:
      assert property (done && we && !reg_op && awu_clr
         |-> addr_ack && !data_ack)
      else $error("array write accepted while locked");
   latch_ready_a:
      assert property (done && quiet |-> addr_ack)
      else $error("not ready after latch-only write");
   busy_nack_a:
      assert property (done && !addr_ack |-> !data_ack)
      else $error("data taken while busy");
endmodule // wpc_link_sva

/* test/write_protect_register_ctrl_tb_top.sv */
// Bench: host and device joined by the link, driven over Wishbone
// and compared with a model of the protection register.
module write_protect_register_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import wpc_pkg::*;
   // Short program time, still long enough for a busy poll to land in it.
   localparam int NV = 40;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic wbwe = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic pin = 1'b0;
   logic [7:0] arr_rd = 8'h00;
   logic ack;
   logic [31:0] rdat;
   logic arr_we;
   logic [11:0] arr_addr;
   logic [7:0] arr_wdata;
   logic busy;
   logic hwp;
   logic [7:0] wpc;
   int bad_count = 0;
   int num_checks = 0;
   int seed = 59;
   int awu = 0, cwu = 0, arm = 0, hi = 0, lo = 0;
   int arr_cnt = 0, arr_seen = 0;
   int tbl[$] = '{12'h000, 12'h7FF, 12'h800, 12'hBFF, 12'hC00, 12'hFFF};

   always #10 clk = ~clk;
   always @(posedge clk)
      if (arr_we === 1'b1)
         arr_seen <= arr_seen + 1;

   wpc_link_if wpc_link_if_i ();
   wpc_host wpc_host_i (.i_core_clk(clk), .i_rst(rst), .i_wb_cyc(cyc),
      .i_wb_stb(stb), .i_wb_we(wbwe), .i_wb_adr(adr), .i_wb_sel(4'hF),
      .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
      .link(wpc_link_if_i.host));
   wpc_dev #(.NV_PROGRAM_CYC(NV)) wpc_dev_i (.i_core_clk(clk), .i_rst(rst),
      .link(wpc_link_if_i.dev), .i_protect_pin(pin), .i_arr_rdata(arr_rd),
      .o_arr_we(arr_we), .o_arr_addr(arr_addr), .o_arr_wdata(arr_wdata),
      .o_busy(busy), .o_hw_protected(hwp), .o_write_protect_control(wpc));
   wpc_link_sva wpc_link_sva_i (.i_core_clk(clk), .i_rst(rst),
      .req(wpc_link_if_i.req), .we(wpc_link_if_i.we),
      .stop(wpc_link_if_i.stop), .addr(wpc_link_if_i.addr),
      .wdata(wpc_link_if_i.wdata), .done(wpc_link_if_i.done),
      .addr_ack(wpc_link_if_i.addr_ack), .data_ack(wpc_link_if_i.data_ack),
      .rdata(wpc_link_if_i.rdata));

   task wrap_up;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task must(input logic c);
      if (c !== 1'b1)
      begin
         bad_count++;
         wrap_up;
      end
   endtask

   task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      wbwe <= w;
      adr <= a;
      wdat <= d;
      for (n = 0; n < 50 && ack !== 1'b1; n++)
         @(posedge clk);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      must(ack);
   endtask

   // One framed link operation; status is returned once done is seen.
   task op(input logic w, input logic [15:0] a, input logic [7:0] d,
      input logic s, output logic [31:0] st);
      int n;
      wb(1'b1, WPC_HOFS_ADDR, {16'h0000, a}, st);
      wb(1'b1, WPC_HOFS_DATA, {24'h000000, d}, st);
      wb(1'b1, WPC_HOFS_CTRL, {29'h0, s, w, 1'b1}, st);
      st = 32'h0;
      for (n = 0; n < 50 && st[1] !== 1'b1; n++)
         wb(1'b0, WPC_HOFS_STAT, 32'h0, st);
      must(st[1]);
   endtask

   function int regv();
      return arm * 128 + hi * 16 + lo * 8 + cwu * 4 + awu * 2;
   endfunction

   function int locked(int a);
      return (hi && lo) || (hi && a >= 12'h800) || (lo && a >= 12'hC00);
   endfunction

   task xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
      input logic s);
      logic [31:0] st;
      int ed;
      int prog;
      int n;
      ed = w ? 1 : -1;
      prog = 0;
      if (w && a != WPC_REG_ADDR)
      begin
         ed = awu;
         prog = awu && !locked(a[11:0]);
      end
      else if (w && s && (d & WPC_RSV_MASK) == 8'h00)
      begin
         if (cwu)
            prog = ((d & 8'h67) == 8'h02 && !(pin && arm)) ? 2 : 0;
         else if (d == 8'h02 || d == 8'h00)
            awu = d[1];
         else if (d == 8'h06 && awu)
            cwu = 1;
      end
      op(w, a, d, s, st);
      chk(st[2], 1);
      if (ed >= 0)
         chk(st[3], ed);
      if (!w)
         chk(st[15:8], a == WPC_REG_ADDR ? regv() : arr_rd);
      if (prog > 0)
      begin
         op(1'b0, WPC_REG_ADDR, 8'h00, 1'b1, st);
         chk(st[3:2], 0);
         for (n = 0; n < 300 && busy !== 1'b0; n++)
            @(posedge clk);
         must(busy === 1'b0);
         repeat (2) @(posedge clk);
         if (prog == 2)
         begin
            arm = d[7];
            hi = d[4];
            lo = d[3];
         end
         else
         begin
            arr_cnt++;
            chk({arr_addr, arr_wdata}, {a[11:0], d});
         end
         cwu = 0;
      end
      chk(wpc, regv());
      chk(hwp, pin && arm);
   endtask

   task rw(input logic [7:0] d);
      xfer(1'b1, WPC_REG_ADDR, d, 1'b1);
   endtask

   task setpin(input logic v);
      @(posedge clk);
      pin <= v;
      @(posedge clk);
   endtask

   initial
   begin
      logic [31:0] r;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      xfer(1'b0, WPC_REG_ADDR, 8'h00, 1'b1);
      xfer(1'b1, 16'h0123, 8'h5A, 1'b1);
      rw(8'h02);
      rw(8'h06);
      rw(8'h00);
      rw(8'h1E);
      xfer(1'b1, WPC_REG_ADDR, 8'h0A, 1'b0);
      rw(8'h4A);
      for (int k = 0; k < 4; k++)
      begin
         rw(8'h06);
         rw(8'(k * 8 + 2));
         foreach (tbl[j])
            xfer(1'b1, 16'(tbl[j]), 8'(k + j), 1'b1);
      end
      rw(8'h06);
      rw(8'h82);
      setpin(1'b1);
      xfer(1'b1, 16'h0100, 8'h33, 1'b1);
      rw(8'h06);
      rw(8'h02);
      setpin(1'b0);
      rw(8'h02);
      rw(8'h00);
      xfer(1'b1, 16'h0100, 8'h44, 1'b1);
      repeat (40)
      begin
         r = $random(seed);
         if (r[31:29] == 3'h0)
            setpin(r[28]);
         @(posedge clk);
         arr_rd <= r[23:16];
         case (r[2:0])
            3'h0: rw(8'h02);
            3'h1: rw(8'h06);
            3'h2: xfer(1'b1, WPC_REG_ADDR,
               {r[7], 2'b00, r[4:3], r[5], 2'b10}, r[6]);
            3'h3: rw(r[15:8]);
            3'h4: xfer(1'b0, r[3] ? WPC_REG_ADDR : {4'h0, r[27:16]},
               8'h00, 1'b1);
            default: xfer(1'b1, {4'h0, r[27:16]}, r[15:8], 1'b1);
         endcase
      end
      rw(8'h02);
      @(posedge clk);
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      awu = 0;
      cwu = 0;
      arm = 0;
      hi = 0;
      lo = 0;
      // A reset in mid-run must drop both latches again.
      xfer(1'b0, WPC_REG_ADDR, 8'h00, 1'b1);
      chk(arr_seen, arr_cnt);
      wrap_up;
   end
endmodule // write_protect_register_ctrl_tb_top
